//--- logic/evt_pkg.sv
// constants for the 8-bit event timer with compare and two output modes
package evt_pkg;
  // register offsets on the plain register port
  localparam logic [1:0] EVT_OFF_MODE  = 2'h0;
  localparam logic [1:0] EVT_OFF_MATCH = 2'h1;
  localparam logic [1:0] EVT_OFF_COUNT = 2'h2;
  localparam logic [1:0] EVT_OFF_PIN   = 2'h3;
  // mode control field positions
  localparam int EVT_BIT_EN     = 7;
  localparam int EVT_BIT_PWM    = 6;
  localparam int EVT_BIT_CSH    = 2;
  localparam int EVT_BIT_CSL    = 1;
  localparam int EVT_BIT_OE     = 0;
  localparam logic [7:0] EVT_MODE_WMASK = 8'hC7;
  // pin control field positions
  localparam int EVT_BIT_DIR    = 1;
  localparam int EVT_BIT_LATCH  = 0;
  // reset values
  localparam logic [7:0] EVT_MODE_RST  = 8'h00;
  localparam logic [7:0] EVT_MATCH_RST = 8'h00;
  localparam logic [7:0] EVT_COUNT_RST = 8'h00;
  localparam logic       EVT_DIR_RST   = 1'b1;
  // clock select codes
  localparam logic [1:0] EVT_CS_SYS  = 2'h0;
  localparam logic [1:0] EVT_CS_DIV  = 2'h1;
  localparam logic [1:0] EVT_CS_RISE = 2'h2;
  localparam logic [1:0] EVT_CS_FALL = 2'h3;
  // prescale divide ratio for the slow internal clock
  localparam int EVT_DIV_RATIO = 256;
endpackage : evt_pkg

//--- logic/evt_timer.sv
// 8-bit event timer: event count, square wave and pwm on a shared pin
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - event mode counts chosen external edge
// - non-pwm match clears count, pulses irq
// - square wave toggles pin every match
// - clearing enable forces square output low
// - output enable starts pin low
// - pwm match raises irq, counter wraps
// - pwm compare below count: high whole cycle
// - pwm compare rewrite may drop one pulse
// - first match may be one count early
// - clock select: sys, sys/256, rise, fall
// - disabled counter holds zero
// - external clock disables timer output
//////////////////////////////////////////////////////////////////////////////
module evt_timer
  import evt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       shared_port_pin_i,
  output logic            shared_port_pin_o,
  output logic            shared_port_pin_oe,
  output logic            match_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] timer_mode_ctrl_q, timer_mode_ctrl_d;
  logic [7:0] match_value_reg_q, match_value_reg_d;
  logic [7:0] event_count_reg_q, event_count_reg_d;
  logic       pin_direction_bit_q, pin_direction_bit_d;
  logic       pin_latch_q, pin_latch_d;
  logic [7:0] reg_rdata_d;
  logic [7:0] prescale_q, prescale_d;
  logic       sync1_q, sync2_q, ext_prev_q;
  logic       timer_out_pin_q, timer_out_pin_d;
  logic       match_irq_d;
  logic       pin_o_d, pin_oe_d;

  logic       count_enable_bit, pwm_select_bit, output_enable_bit;
  logic [1:0] clock_sel;
  logic       tick, hit, ext_count_input;

  assign count_enable_bit  = timer_mode_ctrl_q[EVT_BIT_EN];
  assign pwm_select_bit    = timer_mode_ctrl_q[EVT_BIT_PWM];
  assign output_enable_bit = timer_mode_ctrl_q[EVT_BIT_OE];
  assign clock_sel         = {timer_mode_ctrl_q[EVT_BIT_CSH], timer_mode_ctrl_q[EVT_BIT_CSL]};
  assign ext_count_input   = sync2_q;

  function automatic logic sel_hit(input logic [1:0] a, input logic [1:0] off);
    sel_hit = (a == off);
  endfunction : sel_hit

  //////////////////////////////////////////////////////////////////////////////
  // register port
  always_comb
  begin
    timer_mode_ctrl_d   = timer_mode_ctrl_q;
    match_value_reg_d   = match_value_reg_q;
    pin_direction_bit_d = pin_direction_bit_q;
    pin_latch_d         = pin_latch_q;
    reg_rdata_d         = 8'h00;
    if (reg_wr)
    begin
      if (sel_hit(reg_addr, EVT_OFF_MODE))
        timer_mode_ctrl_d = reg_wdata & EVT_MODE_WMASK;
      if (sel_hit(reg_addr, EVT_OFF_MATCH))
        match_value_reg_d = reg_wdata;
      if (sel_hit(reg_addr, EVT_OFF_PIN))
      begin
        pin_direction_bit_d = reg_wdata[EVT_BIT_DIR];
        pin_latch_d         = reg_wdata[EVT_BIT_LATCH];
      end
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        EVT_OFF_MODE:  reg_rdata_d = timer_mode_ctrl_q;
        EVT_OFF_MATCH: reg_rdata_d = match_value_reg_q;
        EVT_OFF_COUNT: reg_rdata_d = event_count_reg_q;
        EVT_OFF_PIN:   reg_rdata_d = {6'h00, pin_direction_bit_q, pin_latch_q};
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timer_mode_ctrl_q   <= EVT_MODE_RST;
      match_value_reg_q   <= EVT_MATCH_RST;
      pin_direction_bit_q <= EVT_DIR_RST;
      pin_latch_q         <= 1'b0;
      reg_rdata           <= 8'h00;
    end
    else
    begin
      timer_mode_ctrl_q   <= timer_mode_ctrl_d;
      match_value_reg_q   <= match_value_reg_d;
      pin_direction_bit_q <= pin_direction_bit_d;
      pin_latch_q         <= pin_latch_d;
      reg_rdata           <= reg_rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // count pulse selection; the pin is synchronised before edge detection
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q    <= 1'b0;
      sync2_q    <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q    <= shared_port_pin_i;
      sync2_q    <= sync1_q;
      ext_prev_q <= sync2_q;
    end
  end

  // prescaler runs free, so the first slow tick after enable lands anywhere
  // within one count period: the start error is inherent
  always_comb
  begin
    prescale_d = prescale_q + 8'h01;
    unique case (clock_sel)
      EVT_CS_SYS:  tick = 1'b1;
      EVT_CS_DIV:  tick = (prescale_q == 8'(EVT_DIV_RATIO - 1));
      EVT_CS_RISE: tick = ext_count_input & ~ext_prev_q;
      EVT_CS_FALL: tick = ~ext_count_input & ext_prev_q;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter, compare and output
  assign hit = count_enable_bit && tick && (event_count_reg_q == match_value_reg_q);

  always_comb
  begin
    event_count_reg_d = event_count_reg_q;
    timer_out_pin_d   = timer_out_pin_q;
    match_irq_d       = hit;
    if (!count_enable_bit)
    begin
      event_count_reg_d = EVT_COUNT_RST;
      timer_out_pin_d   = 1'b0;
    end
    else if (tick)
    begin
      if (hit && !pwm_select_bit)
        event_count_reg_d = EVT_COUNT_RST;
      else
        event_count_reg_d = event_count_reg_q + 8'h01;
      if (pwm_select_bit)
      begin
        // high from wrap to match; a compare below the count keeps it high
        // until the match in the next 256-count cycle
        if (hit)
          timer_out_pin_d = 1'b0;
        else if (event_count_reg_q == 8'hFF)
          timer_out_pin_d = 1'b1;
      end
      else if (hit)
        timer_out_pin_d = ~timer_out_pin_q;
    end
    if (!output_enable_bit)
      timer_out_pin_d = 1'b0;
  end

  // external count clock forbids timer output on the shared pin
  always_comb
  begin
    pin_oe_d = ~pin_direction_bit_q;
    pin_o_d  = pin_latch_q;
    if (output_enable_bit && !clock_sel[1])
      pin_o_d = pin_latch_q | timer_out_pin_q;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prescale_q         <= 8'h00;
      event_count_reg_q  <= EVT_COUNT_RST;
      timer_out_pin_q    <= 1'b0;
      match_irq          <= 1'b0;
      shared_port_pin_o  <= 1'b0;
      shared_port_pin_oe <= 1'b0;
    end
    else
    begin
      prescale_q         <= prescale_d;
      event_count_reg_q  <= event_count_reg_d;
      timer_out_pin_q    <= timer_out_pin_d;
      match_irq          <= match_irq_d;
      shared_port_pin_o  <= pin_o_d;
      shared_port_pin_oe <= pin_oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_clear_on_match;
    @(posedge clk) disable iff (!rst_b)
      hit && !pwm_select_bit |=> event_count_reg_q == 8'h00;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match) else $error("no clear");

  property p_irq_pulse;
    @(posedge clk) disable iff (!rst_b)
      match_irq |=> !match_irq || $past(hit);
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");

  property p_irq_cause;
    @(posedge clk) disable iff (!rst_b) hit |=> match_irq;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("match without irq");

  property p_hold_zero;
    @(posedge clk) disable iff (!rst_b)
      !count_enable_bit ##1 !count_enable_bit |-> event_count_reg_q == 8'h00;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("disabled count not zero");

  property p_toggle;
    @(posedge clk) disable iff (!rst_b)
      hit && !pwm_select_bit && output_enable_bit ##1 output_enable_bit
        |-> timer_out_pin_q != $past(timer_out_pin_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("square wave not toggled");

  property p_off_low;
    @(posedge clk) disable iff (!rst_b) !count_enable_bit |=> !timer_out_pin_q;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output high while off");

  property p_pwm_wrap;
    @(posedge clk) disable iff (!rst_b)
      hit && pwm_select_bit |=> event_count_reg_q == $past(event_count_reg_q) + 8'h01;
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm count cleared");

  property p_edge_count;
    @(posedge clk) disable iff (!rst_b)
      count_enable_bit && clock_sel == EVT_CS_RISE && !tick && !$past(reg_wr) |=>
        $stable(event_count_reg_q) || !count_enable_bit || $past(reg_wr);
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("count without edge");

  property p_oe_low;
    @(posedge clk) disable iff (!rst_b)
      !output_enable_bit |=> !timer_out_pin_q;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("pin high without enable");

  // with an external count clock the pin only ever shows the port latch
  property p_ext_no_out;
    @(posedge clk) disable iff (!rst_b)
      clock_sel[1] |=> shared_port_pin_o == $past(pin_latch_q);
  endproperty
  a_ext_no_out: assert property (p_ext_no_out) else $error("timer on ext pin");

  property p_irq_single;
    @(posedge clk) disable iff (!rst_b)
      match_irq |-> $past(hit);
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("irq without match");

  // pwm level rises at the wrap so a late compare leaves a full high period
  property p_pwm_rise;
    @(posedge clk) disable iff (!rst_b)
      count_enable_bit && pwm_select_bit && output_enable_bit && tick && !hit &&
        event_count_reg_q == 8'hFF |=> timer_out_pin_q;
  endproperty
  a_pwm_rise: assert property (p_pwm_rise) else $error("pwm not high at wrap");

  c_match_square: cover property (@(posedge clk) disable iff (!rst_b)
    hit && !pwm_select_bit && output_enable_bit);
  c_match_pwm: cover property (@(posedge clk) disable iff (!rst_b) hit && pwm_select_bit);
  c_event_hit: cover property (@(posedge clk) disable iff (!rst_b)
    hit && clock_sel[1] && match_value_reg_q == 8'h00);
  c_pwm_wrap: cover property (@(posedge clk) disable iff (!rst_b)
    pwm_select_bit && tick && event_count_reg_q == 8'hFF);
  c_div_hit: cover property (@(posedge clk) disable iff (!rst_b)
    hit && clock_sel == EVT_CS_DIV);

endmodule : evt_timer

//--- bench/evt_pin_model.sv
// pulse source and pin load on the shared timer pin
`timescale 1ns/1ps
module evt_pin_model (
  input  wire logic clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic pulse,
  input  wire logic idle_hi,
  output logic      pin_i
);
  logic [3:0] n_q = 4'h0;
  //////////////////////////////////////////////////////////////////////////
  // 4 clk away from idle, 4 clk back: edges stay well over 3 clk apart
  always @(posedge clk)
  begin
    if (pulse && n_q == 4'h0)
      n_q <= 4'h8;
    else if (n_q != 4'h0)
      n_q <= n_q - 4'h1;
  end
  // source rests at the level opposite the counted edge
  assign pin_i = pin_oe ? pin_o : (idle_hi ^ (n_q > 4'h4));
endmodule : evt_pin_model

//--- bench/evt_timer_tb.sv
// self-checking bench for the 8-bit event timer
`timescale 1ns/1ps
module evt_timer_tb;
  import evt_pkg::*;
  logic        clk, rst_b, reg_wr, reg_rd, pulse, idle_hi;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        pin_i, pin_o, pin_oe, match_irq, irq_q, pin_q;
  logic [15:0] irq_n, irq_t, irq_dt, tog_t, tog_dt, cyc, irq_dbl;
  int          fail_count, n_checks;
  evt_timer DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shared_port_pin_i(pin_i),
    .shared_port_pin_o(pin_o), .shared_port_pin_oe(pin_oe), .match_irq(match_irq));
  evt_pin_model u_pin (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pulse(pulse),
    .idle_hi(idle_hi), .pin_i(pin_i));
  always #10 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  // interval monitors; 10000 cycles is several times the whole run
  always @(posedge clk)
  begin
    cyc <= cyc + 16'h1;
    irq_q <= match_irq;
    pin_q <= pin_o;
    if (match_irq === 1'b1)
    begin
      irq_n <= irq_n + 16'h1;
      irq_dt <= cyc - irq_t;
      irq_t <= cyc;
    end
    if (match_irq === 1'b1 && irq_q === 1'b1)
      irq_dbl <= irq_dbl + 16'h1;
    if (pin_o !== pin_q)
    begin
      tog_dt <= cyc - tog_t;
      tog_t <= cyc;
    end
    if (cyc == 16'h2710)
    begin
      fail_count++;
      end_of_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task pls(input int k);
    repeat (k)
    begin
      @(posedge clk);
      pulse <= 1'b1;
      @(posedge clk);
      pulse <= 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask : pls
  task wait_irq(input int k);
    logic [15:0] t;
    t = irq_n + 16'(k);
    for (int i = 0; i < 2000 && irq_n != t; i++) @(negedge clk);
    chk(irq_n, t);
  endtask : wait_irq
  //////////////////////////////////////////////////////////////////////////
  task t_event;
    logic [15:0] n0;
    wr(EVT_OFF_MODE, 8'h04);
    wr(EVT_OFF_MATCH, 8'h02);
    wr(EVT_OFF_MODE, 8'h84);
    n0 = irq_n;
    pls(2);
    rd(EVT_OFF_COUNT, 8'h02);
    chk(irq_n - n0, 16'h0);
    pls(1);
    chk(irq_n - n0, 16'h1);
    rd(EVT_OFF_COUNT, 8'h00);
    wr(EVT_OFF_MODE, 8'h06);
    idle_hi <= 1'b1;
    wr(EVT_OFF_MATCH, 8'h00);
    wr(EVT_OFF_MODE, 8'h86);
    n0 = irq_n;
    pls(3);
    chk(irq_n - n0, 16'h3);
    wr(EVT_OFF_MODE, 8'h06);
  endtask : t_event
  task t_square;
    wr(EVT_OFF_PIN, 8'h00);
    wr(EVT_OFF_MODE, 8'h01);
    repeat (2) @(negedge clk);
    chk(pin_oe, 16'h1);
    chk(pin_o, 16'h0);
    wr(EVT_OFF_MATCH, 8'h03);
    wr(EVT_OFF_MODE, 8'h81);
    wait_irq(3);
    chk(irq_dt, 16'h4);
    chk(tog_dt, 16'h4);
    wr(EVT_OFF_MODE, 8'h01);
    // level clears one edge after the write and reaches the pin one edge later
    repeat (3) @(negedge clk);
    chk(pin_o, 16'h0);
    rd(EVT_OFF_COUNT, 8'h00);
  endtask : t_square
  task t_div_pwm;
    wr(EVT_OFF_MODE, 8'h03);
    wr(EVT_OFF_MATCH, 8'h00);
    wr(EVT_OFF_MODE, 8'h83);
    wait_irq(3);
    chk(irq_dt, 16'(EVT_DIV_RATIO));
    wr(EVT_OFF_MODE, 8'h41);
    wr(EVT_OFF_MATCH, 8'h40);
    wr(EVT_OFF_MODE, 8'hC1);
    wait_irq(3);
    chk(irq_dt, 16'h0100);
    // high from the wrap through count 40h: 41h cycles; the fall is logged next edge
    @(negedge clk);
    chk(tog_dt, 16'h0041);
    wr(EVT_OFF_MODE, 8'h41);
  endtask : t_div_pwm
  task end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clk, rst_b, reg_wr, reg_rd, pulse, idle_hi, irq_q, pin_q} = 8'h00;
    {reg_addr, reg_wdata} = 10'h000;
    {irq_n, irq_t, irq_dt, tog_t, tog_dt, cyc, irq_dbl} = 112'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(EVT_OFF_MODE, EVT_MODE_RST);
    rd(EVT_OFF_MATCH, EVT_MATCH_RST);
    rd(EVT_OFF_COUNT, EVT_COUNT_RST);
    rd(EVT_OFF_PIN, 8'h02);
    t_event();
    t_square();
    t_div_pwm();
    chk(irq_dbl, 16'h0);
    end_of_test();
  end
endmodule : evt_timer_tb
